// ===== hw/scb_regs.svh
// register offsets, field positions and reset values of the system control register bank
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH
`define SCB_ADDR_SUM_TOP 8'hE5
`define SCB_ADDR_TRIM 8'hE6
`define SCB_ADDR_SUPPLY 8'hE7
`define SCB_ADDR_EIRQ 8'hE8
`define SCB_ADDR_PCODE_LO 8'hE9
`define SCB_ADDR_PCODE_HI 8'hEA
`define SCB_ADDR_SIVER 8'hEB
`define SCB_ADDR_FLASH_CTL 8'hEE
`define SCB_ADDR_FLASH_TIM 8'hEF
`define SCB_ADDR_ACC_B 8'hF0
`define SCB_ADDR_PWRDN 8'hF1
`define SCB_ADDR_PINSEL 8'hF2
`define SCB_ADDR_PLL_LO 8'hF4
`define SCB_ADDR_PLL_HI 8'hF5
`define SCB_RST_SUPPLY 8'h8F
`define SCB_RST_EIRQ 8'hE0
`define SCB_RST_FLASH_TIM 8'hA5
`define SCB_RST_PWRDN 8'h6F
`define SCB_RST_ZERO 8'h00
`define SCB_RST_PLL_LO 8'h00
`define SCB_RST_PLL_HI 2'h0
`define SCB_TRIM_OFF_POS 8'h00
`define SCB_TRIM_OFF_NEG 8'h80
`define SCB_SUPPLY_OFF_BIT 7
`define SCB_THRESH_MAX 4'h7
`define SCB_EIRQ_ONES 3'h7
`define SCB_PAGE_ERASE_ENABLE_BIT 6
`define SCB_DELAY_BIT 4
`define SCB_BUSY_BIT 2
`define SCB_PD_CLK 7
`define SCB_PD_IDAC 6
`define SCB_PD_TWI 5
`define SCB_PD_ADC 3
`define SCB_PD_WDT 2
`define SCB_PD_ST 1
`define SCB_PD_SPI 0
`define SCB_PIN_GPIO 5'h00
`define SCB_PIN_SYSCLK 5'h01
`define SCB_PIN_DIV2_BIT 4
`define SCB_PIN_SYSCLK_DIV2 5'h11
`define SCB_LOCK_BIT 4
`define SCB_WRITE_UNIT 4'h5
`define SCB_CLK_EXT 3'h3
`define SCB_PLL_LOCK_MS 20
`define SCB_CLK_MHZ 250
`endif

// ===== hw/scb_pkg.sv
// types shared by the system control register bank
package scb_pkg;
  typedef struct packed {
    logic osc_pll_power_down;
    logic current_dac_power_down;
    logic twowire_power_down;
    logic converter_power_down;
    logic watchdog_power_down;
    logic system_timer_power_down;
    logic serial_periph_power_down;
  } scb_power_s;
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scb_sfr_req_s;
  typedef enum logic [2:0] {
    SCB_FL_IDLE = 3'b001,
    SCB_FL_WRITE = 3'b010,
    SCB_FL_ERASE = 3'b100
  } scb_flash_e;
endpackage

// ===== hw/scb_bank.sv
// system control special-function register bank
`timescale 1ns/100ps
`include "scb_regs.svh"
module scb_bank
  import scb_pkg::*;
#(
  parameter logic [7:0] SILICON_VERSION = 8'h11, // arbitrary value
  parameter logic [7:0] PRODUCT_CODE_HIGH = 8'h5A, // arbitrary value
  parameter logic PROD_VARIANT = 1'b0,
  parameter logic PROD_MEMORY = 1'b0,
  parameter int PLL_LOCK_CYCLES = `SCB_PLL_LOCK_MS * `SCB_CLK_MHZ * 1000
)(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire scb_sfr_req_s i_sfr,
  input wire logic [31:0] i_sum_acc,
  input wire logic i_sum_load,
  input wire logic i_supply_low,
  input wire logic i_prog_mode,
  input wire logic i_serial_prog,
  input wire logic i_flash_write_go,
  input wire logic i_flash_erase_go,
  input wire logic [5:0] i_microsecond_divider,
  input wire logic [15:0] i_millisecond_divider,
  input wire logic [2:0] i_active_clock_source,
  input wire logic i_pll_ref_locked,
  input wire logic [13:0] i_pin_sources,
  output logic [7:0] o_rdata,
  output logic [7:0] o_sum_top,
  output logic o_trim_enable,
  output logic o_trim_negative,
  output logic [6:0] o_trim_magnitude,
  output logic o_supply_detect_on,
  output logic [3:0] o_analog_supply_threshold,
  output logic o_supply_low_flag,
  output logic o_supply_low_irq,
  output logic [4:0] o_irq_enables,
  output logic o_page_erase_enable,
  output logic o_flash_delay_line_select,
  output logic o_flash_pulse,
  output logic [7:0] o_second_accumulator,
  output scb_power_s o_power_down,
  output logic o_twowire_powered,
  output logic o_converter_powered,
  output logic o_osc_pll_off,
  output logic o_aux_pin,
  output logic [9:0] o_pll_multiplier,
  output logic o_pll_detect_en
);
  logic [7:0] sum_top_reg, trim_reg, supply_reg, eirq_reg, fctl_reg, ftim_reg, accb_reg, pwr_reg, pin_reg;
  logic [7:0] pll_lo_reg;
  logic [1:0] pll_hi_reg;
  logic lock_en_reg, locked_reg, low_flag_reg, busy_reg, pin_div_reg, pin_out_reg, pin_src_prev_reg;
  logic [7:0] rdata_reg;
  logic [31:0] lock_cnt_reg;
  logic [23:0] unit_cnt_reg;
  logic [3:0] mult_cnt_reg;
  logic [1:0] sup_sync, ref_sync;
  logic supply_seen;
  scb_flash_e fl_state, fl_next;
  wire wr = i_sfr.sel & i_sfr.wr;
  wire rd = i_sfr.sel & i_sfr.rd;
  wire [7:0] a = i_sfr.addr;
  wire [7:0] d = i_sfr.wdata;
  wire wr_sum = wr && a == `SCB_ADDR_SUM_TOP;
  wire wr_trim = wr && a == `SCB_ADDR_TRIM;
  wire wr_sup = wr && a == `SCB_ADDR_SUPPLY;
  wire wr_eirq = wr && a == `SCB_ADDR_EIRQ;
  wire wr_fctl = wr && a == `SCB_ADDR_FLASH_CTL;
  wire wr_ftim = wr && a == `SCB_ADDR_FLASH_TIM;
  wire wr_accb = wr && a == `SCB_ADDR_ACC_B;
  wire wr_pwr = wr && a == `SCB_ADDR_PWRDN;
  wire wr_pin = wr && a == `SCB_ADDR_PINSEL;
  wire wr_pllo = wr && a == `SCB_ADDR_PLL_LO;
  wire wr_plhi = wr && a == `SCB_ADDR_PLL_HI;
  wire pd_adc = pwr_reg[`SCB_PD_ADC];
  // summation follows the accumulator only while the converter domain is powered
  wire [7:0] sum_top_next = pd_adc ? `SCB_RST_ZERO : (i_sum_load ? i_sum_acc[31:24] : (wr_sum ? d : sum_top_reg));
  wire thresh_ok = supply_reg[3:0] <= `SCB_THRESH_MAX;
  wire detect_on = ~supply_reg[`SCB_SUPPLY_OFF_BIT] & thresh_ok;
  wire is_ext_clk = i_active_clock_source == `SCB_CLK_EXT;
  wire [4:0] pin_code = pin_reg[7:3];
  wire [2:0] pin_idx = pin_code[3:1];
  wire pin_src = i_pin_sources[pin_idx];
  wire pin_div_mode = pin_code[0] & pin_code[`SCB_PIN_DIV2_BIT];
  wire pin_src_rise = pin_src & ~pin_src_prev_reg;
  // code 10001 divides the system clock itself, so it steps every cycle
  wire pin_div_step = (pin_code == `SCB_PIN_SYSCLK_DIV2) | pin_src_rise;
  wire [7:0] fctl_rd = {1'b0, fctl_reg[`SCB_PAGE_ERASE_ENABLE_BIT], 1'b0, fctl_reg[`SCB_DELAY_BIT], 1'b0, busy_reg,
                        i_serial_prog & i_prog_mode, i_prog_mode};
  wire [23:0] erase_units = {8'h00, i_millisecond_divider} + 24'h1;
  wire [23:0] write_units = ({18'h0, i_microsecond_divider} + 24'h1) * {20'h0, `SCB_WRITE_UNIT};
  wire [23:0] unit_len = (fl_state == SCB_FL_ERASE) ? erase_units : write_units;
  logic [7:0] rd_mux;
  always_comb begin
    fl_next = fl_state;
    unique case (fl_state)
      SCB_FL_IDLE: begin
        if (i_flash_erase_go) begin
          fl_next = SCB_FL_ERASE;
        end else if (i_flash_write_go) begin
          fl_next = SCB_FL_WRITE;
        end
      end
      SCB_FL_WRITE, SCB_FL_ERASE: begin
        if (unit_cnt_reg == 24'h1 && mult_cnt_reg == 4'h0) begin
          fl_next = SCB_FL_IDLE;
        end
      end
      default: fl_next = SCB_FL_IDLE;
    endcase
  end
  always_comb begin
    unique case (a)
      `SCB_ADDR_SUM_TOP: rd_mux = sum_top_reg;
      `SCB_ADDR_TRIM: rd_mux = trim_reg;
      `SCB_ADDR_SUPPLY: rd_mux = {supply_reg[7], 3'h0, supply_reg[3:0]};
      `SCB_ADDR_EIRQ: rd_mux = {`SCB_EIRQ_ONES, eirq_reg[4:0]};
      `SCB_ADDR_PCODE_LO: rd_mux = {6'h00, PROD_VARIANT, PROD_MEMORY};
      `SCB_ADDR_PCODE_HI: rd_mux = PRODUCT_CODE_HIGH;
      `SCB_ADDR_SIVER: rd_mux = SILICON_VERSION;
      `SCB_ADDR_FLASH_CTL: rd_mux = fctl_rd;
      `SCB_ADDR_FLASH_TIM: rd_mux = ftim_reg;
      `SCB_ADDR_ACC_B: rd_mux = accb_reg;
      `SCB_ADDR_PWRDN: rd_mux = {pwr_reg[7:5], 1'b0, pwr_reg[3:0]};
      `SCB_ADDR_PINSEL: rd_mux = {pin_reg[7:3], 3'h0};
      `SCB_ADDR_PLL_LO: rd_mux = pll_lo_reg;
      `SCB_ADDR_PLL_HI: rd_mux = {i_active_clock_source, locked_reg, 2'h0, pll_hi_reg};
      default: rd_mux = `SCB_RST_ZERO;
    endcase
  end
  // two-flop synchronisers for analog comparator and pll lock detector
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sup_sync <= 2'h0;
      ref_sync <= 2'h0;
    end else begin
      sup_sync <= {sup_sync[0], i_supply_low};
      ref_sync <= {ref_sync[0], i_pll_ref_locked};
    end
  end
  assign supply_seen = sup_sync[1];
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sum_top_reg <= `SCB_RST_ZERO;
    end else begin
      sum_top_reg <= sum_top_next;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trim_reg <= `SCB_RST_ZERO;
    end else if (wr_trim) begin
      trim_reg <= d;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      supply_reg <= `SCB_RST_SUPPLY;
    end else if (wr_sup) begin
      supply_reg <= {d[7], 3'h0, d[3:0]};
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      eirq_reg <= `SCB_RST_EIRQ;
    end else if (wr_eirq) begin
      eirq_reg <= {`SCB_EIRQ_ONES, d[4:0]};
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ftim_reg <= `SCB_RST_FLASH_TIM;
    end else if (wr_ftim) begin
      ftim_reg <= d;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      accb_reg <= `SCB_RST_ZERO;
    end else if (wr_accb) begin
      accb_reg <= d;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwr_reg <= `SCB_RST_PWRDN;
    end else if (wr_pwr) begin
      pwr_reg <= {d[7:5], 1'b0, d[3:0]};
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_reg <= `SCB_RST_ZERO;
    end else if (wr_pin) begin
      pin_reg <= {d[7:3], 3'h0};
    end
  end
  // only page erase and delay line bits are writable, in any mode
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fctl_reg <= `SCB_RST_ZERO;
    end else if (wr_fctl) begin
      fctl_reg <= {1'b0, d[`SCB_PAGE_ERASE_ENABLE_BIT], 1'b0, d[`SCB_DELAY_BIT], 4'h0};
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pll_lo_reg <= `SCB_RST_PLL_LO;
    end else if (wr_pllo) begin
      pll_lo_reg <= d;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pll_hi_reg <= `SCB_RST_PLL_HI;
    end else if (wr_plhi) begin
      pll_hi_reg <= d[1:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= `SCB_RST_ZERO;
    end else if (rd) begin
      rdata_reg <= rd_mux;
    end
  end
  // supply flag: a new low event wins over the clearing read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_flag_reg <= 1'b0;
    end else if (detect_on && supply_seen) begin
      low_flag_reg <= 1'b1;
    end else if (!detect_on || (rd && a == `SCB_ADDR_SUPPLY)) begin
      low_flag_reg <= 1'b0;
    end
  end
  // lock detection waits the settle time before trusting the detector
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_en_reg <= 1'b0;
      lock_cnt_reg <= 32'h0;
      locked_reg <= 1'b0;
    end else begin
      if (wr_plhi && d[`SCB_LOCK_BIT]) begin
        lock_en_reg <= 1'b1;
        lock_cnt_reg <= 32'h0;
        locked_reg <= 1'b0;
      end else if (lock_en_reg) begin
        if (lock_cnt_reg < 32'(PLL_LOCK_CYCLES)) begin
          lock_cnt_reg <= lock_cnt_reg + 32'h1;
        end
        locked_reg <= ref_sync[1] && lock_cnt_reg >= 32'(PLL_LOCK_CYCLES);
      end
    end
  end
  // pulse length is counted as units of divider periods
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fl_state <= SCB_FL_IDLE;
      busy_reg <= 1'b0;
      unit_cnt_reg <= 24'h0;
      mult_cnt_reg <= 4'h0;
    end else begin
      fl_state <= fl_next;
      busy_reg <= fl_next != SCB_FL_IDLE;
      if (fl_state == SCB_FL_IDLE) begin
        mult_cnt_reg <= i_flash_erase_go ? ftim_reg[7:4] : ftim_reg[3:0];
        unit_cnt_reg <= i_flash_erase_go ? erase_units : write_units;
      end else if (unit_cnt_reg == 24'h1) begin
        unit_cnt_reg <= unit_len;
        mult_cnt_reg <= mult_cnt_reg - 4'h1;
      end else begin
        unit_cnt_reg <= unit_cnt_reg - 24'h1;
      end
    end
  end
  // divide-by-two codes other than 10001 toggle on rising edges of the chosen source
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_div_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_src_prev_reg <= 1'b0;
    end else begin
      pin_src_prev_reg <= pin_src;
      // restart low on leaving a divide code so the phase is known
      if (!pin_div_mode) begin
        pin_div_reg <= 1'b0;
      end else if (pin_div_step) begin
        pin_div_reg <= ~pin_div_reg;
      end
      if (pin_code == `SCB_PIN_GPIO) begin
        pin_out_reg <= 1'b0;
      end else if (pin_code == `SCB_PIN_SYSCLK) begin
        pin_out_reg <= ~pin_out_reg;
      end else if (pin_code[0]) begin
        pin_out_reg <= pin_code[`SCB_PIN_DIV2_BIT] ? pin_div_reg : pin_src;
      end
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_trim_enable <= 1'b0;
    end else begin
      o_trim_enable <= trim_reg != `SCB_TRIM_OFF_POS && trim_reg != `SCB_TRIM_OFF_NEG;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_supply_low_irq <= 1'b0;
    end else begin
      o_supply_low_irq <= detect_on && supply_seen;
    end
  end
  // reserved threshold codes count as detection off
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_supply_detect_on <= 1'b0;
    end else begin
      o_supply_detect_on <= detect_on;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flash_pulse <= 1'b0;
    end else begin
      o_flash_pulse <= fl_next != SCB_FL_IDLE;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_twowire_powered <= 1'b0;
    end else begin
      o_twowire_powered <= ~pwr_reg[`SCB_PD_TWI] & pwr_reg[`SCB_PD_SPI];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_converter_powered <= 1'b0;
    end else begin
      o_converter_powered <= ~pwr_reg[`SCB_PD_ADC];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_osc_pll_off <= 1'b0;
    end else begin
      o_osc_pll_off <= pwr_reg[`SCB_PD_CLK] & is_ext_clk;
    end
  end
  assign o_rdata = rdata_reg;
  assign o_sum_top = sum_top_reg;
  assign o_trim_negative = trim_reg[7];
  assign o_trim_magnitude = trim_reg[6:0];
  assign o_analog_supply_threshold = supply_reg[3:0];
  assign o_supply_low_flag = low_flag_reg;
  assign o_irq_enables = eirq_reg[4:0];
  assign o_page_erase_enable = fctl_reg[`SCB_PAGE_ERASE_ENABLE_BIT];
  assign o_flash_delay_line_select = fctl_reg[`SCB_DELAY_BIT];
  assign o_second_accumulator = accb_reg;
  assign o_power_down = {pwr_reg[7:5], pwr_reg[3:0]};
  assign o_pll_multiplier = {pll_hi_reg, pll_lo_reg};
  assign o_pll_detect_en = lock_en_reg;
  assign o_aux_pin = pin_out_reg;
endmodule

// ===== tb/scb_bank_assertions.sv
// concurrent checks on the ports of the system control register bank
`timescale 1ns/100ps
module scb_bank_assertions
  import scb_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire scb_sfr_req_s i_sfr,
  input wire logic [31:0] i_sum_acc,
  input wire logic i_sum_load,
  input wire logic i_flash_write_go,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_sum_top,
  input wire logic o_trim_enable,
  input wire logic o_supply_detect_on,
  input wire logic [4:0] o_irq_enables,
  input wire logic o_flash_pulse,
  input wire scb_power_s o_power_down,
  input wire logic o_twowire_powered,
  input wire logic o_converter_powered,
  input wire logic [9:0] o_pll_multiplier,
  input wire logic o_pll_detect_en
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_wr(logic [7:0] a);
    i_sfr.sel && i_sfr.wr && i_sfr.addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_sfr.sel && i_sfr.rd && !i_sfr.wr && i_sfr.addr == a;
  endsequence
  a_trim_off_codes: assert property (s_wr(8'hE6) |-> ##2 o_trim_enable == ($past(i_sfr.wdata[6:0], 2) != 7'h00))
    else $error("trim enable does not follow written code");
  a_irq_enable_write: assert property (s_wr(8'hE8) |=> o_irq_enables == $past(i_sfr.wdata[4:0]))
    else $error("irq enables not taken from write");
  a_irq_read_ones: assert property (s_rd(8'hE8) |=> o_rdata == {3'h7, $past(o_irq_enables)})
    else $error("irq enable read lacks constant ones");
  a_unmapped_read: assert property (s_rd(8'hEC) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sum_top_load: assert property (i_sum_load && !o_power_down.converter_power_down |=>
    o_sum_top == $past(i_sum_acc[31:24]))
    else $error("summation top byte not loaded");
  a_supply_detect_off: assert property (s_wr(8'hE7) ##0 i_sfr.wdata[7] |-> ##2 !o_supply_detect_on)
    else $error("supply detect still on");
  a_twowire_power: assert property ($stable(o_power_down) |->
    o_twowire_powered == (!o_power_down.twowire_power_down && o_power_down.serial_periph_power_down))
    else $error("two-wire power wrong");
  a_converter_power: assert property ($stable(o_power_down) |->
    o_converter_powered == !o_power_down.converter_power_down)
    else $error("converter power wrong");
  a_flash_pulse_start: assert property (i_flash_write_go && !o_flash_pulse |=> o_flash_pulse)
    else $error("write pulse did not start");
  a_pll_low_write: assert property (s_wr(8'hF4) |=> o_pll_multiplier[7:0] == $past(i_sfr.wdata))
    else $error("pll multiplier low byte not written");
  a_lock_detect_on: assert property (s_wr(8'hF5) ##0 i_sfr.wdata[4] |=> o_pll_detect_en)
    else $error("lock detection not enabled");
endmodule

// ===== tb/tb_system_control_sfr_bank.sv
// self-checking bench for the system control register bank
`timescale 1ns/100ps
module tb_system_control_sfr_bank
  import scb_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  scb_sfr_req_s i_sfr = '0;
  logic [31:0] i_sum_acc = 32'hA1B2C3D4;
  logic i_sum_load = 1'b0, i_supply_low = 1'b0, i_prog_mode = 1'b0, i_serial_prog = 1'b0;
  logic i_flash_write_go = 1'b0, i_flash_erase_go = 1'b0, i_pll_ref_locked = 1'b0;
  logic [5:0] i_microsecond_divider = 6'h01;
  logic [15:0] i_millisecond_divider = 16'h0003;
  logic [2:0] i_active_clock_source = 3'h3;
  logic [13:0] i_pin_sources = 14'h0000;
  logic [7:0] o_rdata, o_sum_top, o_second_accumulator, rv;
  logic [6:0] o_trim_magnitude;
  logic [3:0] o_analog_supply_threshold;
  logic [4:0] o_irq_enables;
  logic [9:0] o_pll_multiplier;
  scb_power_s o_power_down;
  logic o_trim_enable, o_trim_negative, o_supply_detect_on, o_supply_low_flag, o_supply_low_irq;
  logic o_page_erase_enable, o_flash_delay_line_select, o_flash_pulse, o_twowire_powered;
  logic o_converter_powered, o_osc_pll_off, o_aux_pin, o_pll_detect_en;
  int error_cnt = 0, compares = 0, pw = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_flash_pulse === 1'b1) pw <= pw + 1;
  // lock count cut to 50 cycles so the run stays short
  scb_bank #(.PLL_LOCK_CYCLES(50)) scb_bank_inst (.*);
  task automatic close_out;
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) i_sfr <= '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge i_sys_clk) i_sfr <= '0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk) i_sfr <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
    @(posedge i_sys_clk) i_sfr <= '0;
    step(1);
    rv = o_rdata;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rv});
  endtask
  task automatic t_reset;
    logic [7:0] a [12] = '{8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hEC};
    logic [7:0] e [12] = '{8'h00, 8'h00, 8'h8F, 8'hE0, 8'h00, 8'h5A, 8'h11, 8'hA5, 8'h00, 8'h6F, 8'h00, 8'h00};
    foreach (a[i]) rdchk(a[i], e[i]);
    chk("power", 16'h003F, 16'(o_power_down));
  endtask
  task automatic t_consts;
    wr(8'hE9, 8'hFF);
    rdchk(8'hE9, 8'h00);
    wr(8'hEA, 8'h00);
    rdchk(8'hEA, 8'h5A);
    wr(8'hE8, 8'h00);
    rdchk(8'hE8, 8'hE0);
    wr(8'hE8, 8'h1F);
    rdchk(8'hE8, 8'hFF);
    wr(8'hF2, 8'hFF);
    rdchk(8'hF2, 8'hF8);
    wr(8'hE7, 8'hFF);
    rdchk(8'hE7, 8'h8F);
  endtask
  task automatic t_trim;
    logic [7:0] c [4] = '{8'h85, 8'h80, 8'h05, 8'h00};
    foreach (c[i]) begin
      wr(c[i] == 8'h00 ? 8'hE6 : 8'hE6, c[i]);
      step(2);
      chk("trim on", {15'h0, c[i][6:0] != 7'h00}, {15'h0, o_trim_enable});
      chk("trim sign", {15'h0, c[i][7]}, {15'h0, o_trim_negative});
      chk("trim mag", {9'h0, c[i][6:0]}, {9'h0, o_trim_magnitude});
    end
  endtask
  task automatic t_sum;
    wr(8'hF1, 8'h67);
    @(posedge i_sys_clk) i_sum_load <= 1'b1;
    @(posedge i_sys_clk) i_sum_load <= 1'b0;
    rdchk(8'hE5, 8'hA1);
    wr(8'hF0, 8'h5C);
    rdchk(8'hF0, 8'h5C);
    chk("second acc", 16'h005C, {8'h00, o_second_accumulator});
  endtask
  task automatic t_supply;
    int i;
    wr(8'hE7, 8'h03);
    step(2);
    chk("detect on", 16'h0001, {15'h0, o_supply_detect_on});
    chk("threshold", 16'h0003, {12'h0, o_analog_supply_threshold});
    @(posedge i_sys_clk) i_supply_low <= 1'b1;
    for (i = 0; i < 10 && o_supply_low_flag !== 1'b1; i++) step(1);
    if (i == 10) begin
      error_cnt++;
      close_out();
    end
    chk("low irq", 16'h0001, {15'h0, o_supply_low_irq});
    @(posedge i_sys_clk) i_supply_low <= 1'b0;
    step(4);
    chk("low flag held", 16'h0001, {15'h0, o_supply_low_flag});
    rdchk(8'hE7, 8'h03);
    step(2);
    chk("low flag", 16'h0000, {15'h0, o_supply_low_flag});
    wr(8'hE7, 8'h09);
    step(2);
    chk("reserved code", 16'h0000, {15'h0, o_supply_detect_on});
    wr(8'hE7, 8'h83);
    step(2);
    chk("detect off", 16'h0000, {15'h0, o_supply_detect_on});
  endtask
  task automatic t_pulse(input logic er, input int exp);
    int i;
    pw = 0;
    @(posedge i_sys_clk) {i_flash_erase_go, i_flash_write_go} <= {er, !er};
    @(posedge i_sys_clk) {i_flash_erase_go, i_flash_write_go} <= 2'b00;
    rdchk(8'hEE, 8'h04);
    for (i = 0; i < 200 && o_flash_pulse !== 1'b0; i++) step(1);
    if (i == 200) begin
      error_cnt++;
      close_out();
    end
    chk("pulse length", exp[15:0], pw[15:0]);
    rdchk(8'hEE, 8'h00);
  endtask
  task automatic t_flash;
    logic [1:0] m [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
    logic [7:0] e [4] = '{8'h00, 8'h01, 8'h03, 8'h00};
    foreach (m[i]) begin
      @(posedge i_sys_clk) {i_prog_mode, i_serial_prog} <= m[i];
      rdchk(8'hEE, e[i]);
    end
    @(posedge i_sys_clk) {i_prog_mode, i_serial_prog} <= 2'b00;
    wr(8'hEE, 8'hFF);
    rdchk(8'hEE, 8'h50);
    chk("erase mode", 16'h0001, {15'h0, o_page_erase_enable});
    chk("delay line", 16'h0001, {15'h0, o_flash_delay_line_select});
    wr(8'hEE, 8'h00);
    wr(8'hEF, 8'h12);
    t_pulse(1'b0, 30);
    t_pulse(1'b1, 8);
  endtask
  task automatic t_power;
    wr(8'hF1, 8'h01);
    step(2);
    chk("twi on", 16'h0001, {15'h0, o_twowire_powered});
    chk("adc on", 16'h0001, {15'h0, o_converter_powered});
    wr(8'hF1, 8'h28);
    step(2);
    chk("twi off", 16'h0000, {15'h0, o_twowire_powered});
    chk("adc off", 16'h0000, {15'h0, o_converter_powered});
    wr(8'hF1, 8'h80);
    step(2);
    chk("osc off", 16'h0001, {15'h0, o_osc_pll_off});
    @(posedge i_sys_clk) i_active_clock_source <= 3'h6;
    step(2);
    chk("osc kept", 16'h0000, {15'h0, o_osc_pll_off});
  endtask
  task automatic t_pll;
    @(posedge i_sys_clk) i_pll_ref_locked <= 1'b1;
    wr(8'hF4, 8'h34);
    wr(8'hF5, 8'h13);
    step(1);
    chk("pll mult", 16'h0334, {6'h0, o_pll_multiplier});
    chk("lock detect", 16'h0001, {15'h0, o_pll_detect_en});
    step(60);
    rdchk(8'hF5, 8'hD3);
    @(posedge i_sys_clk) i_active_clock_source <= 3'h3;
    rdchk(8'hF5, 8'h73);
  endtask
  task automatic t_pin;
    logic a0;
    wr(8'hF2, 8'h00);
    step(2);
    chk("pin gpio", 16'h0000, {15'h0, o_aux_pin});
    wr(8'hF2, 8'h08);
    step(2);
    a0 = o_aux_pin;
    step(1);
    chk("pin clock", {15'h0, ~a0}, {15'h0, o_aux_pin});
    wr(8'hF2, 8'h18);
    @(posedge i_sys_clk) i_pin_sources <= 14'h0002;
    step(3);
    chk("pin source", 16'h0001, {15'h0, o_aux_pin});
    wr(8'hF2, 8'h98);
    @(posedge i_sys_clk) i_pin_sources <= 14'h0000;
    @(posedge i_sys_clk) i_pin_sources <= 14'h0002;
    step(3);
    chk("pin half rise", 16'h0001, {15'h0, o_aux_pin});
    step(4);
    chk("pin half hold", 16'h0001, {15'h0, o_aux_pin});
    @(posedge i_sys_clk) i_pin_sources <= 14'h0000;
    @(posedge i_sys_clk) i_pin_sources <= 14'h0002;
    step(3);
    chk("pin half fall", 16'h0000, {15'h0, o_aux_pin});
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    step(1);
    t_reset();
    t_consts();
    t_trim();
    t_sum();
    t_supply();
    t_flash();
    t_power();
    t_pll();
    t_pin();
    close_out();
  end
endmodule
bind scb_bank scb_bank_assertions scb_bank_assertions_inst (.*);
